// ### pkg/refresh_defs.vh
`ifndef REFRESH_DEFS_VH
`define REFRESH_DEFS_VH
// Offsets within the peripheral register file
`define OFS_REFRESH_BASE 8'hB0
`define OFS_REFRESH_TIME 8'hB2
`define OFS_REFRESH_CTRL 8'hB4
// Relocation register of the peripheral register file
`define OFS_RELOCATION 8'hA8
// Field positions
`define CTRL_ENABLE_BIT 15
`define RELOC_IO_BIT 12
// Reset values
`define RST_REFRESH_BASE 16'h0000
`define RST_REFRESH_TIME 16'h0000
`define RST_REFRESH_CTRL 16'h0000
`define RST_RELOCATION 16'h00FF
`endif

// ### rtl/memory_refresh_sequencer.v
`timescale 1ns/100ps
`default_nettype none
`include "refresh_defs.vh"

// Contract
// - Periodic refresh read cycles without software action
// - Nine-bit clock counter sets refresh spacing
// - Twelve-bit row address drives A12:1
// - Programmable A19:13 selects 8 Kbyte block
// - Registers live in 128x16 peripheral register file
// - Register file relocatable, memory or I/O, 256B
module memory_refresh_sequencer #(
  parameter CNT_W = 9,
  parameter ROW_W = 12
) (
  input wire REF_CLK,
  input wire NRST,
  input wire BUS_SEL,
  input wire BUS_IO,
  input wire [19:0] BUS_ADDR,
  input wire BUS_WR,
  input wire BUS_RD,
  input wire [15:0] BUS_WDATA,
  output reg [15:0] BUS_RDATA,
  output wire BUS_HIT,
  output wire REFRESH_REQ,
  input wire REFRESH_DONE,
  output reg [19:0] REFRESH_ADDR
);

  // ------------------------------------------------------------
  // Constants and states
  // ------------------------------------------------------------
  localparam [0:0] ST_IDLE = 1'b0;
  localparam [0:0] ST_PEND = 1'b1;
  localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
  localparam [ROW_W-1:0] ROW_ONE = {{(ROW_W-1){1'b0}}, 1'b1};

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  reg [15:0] base_q;
  reg [15:0] base_d;
  reg [15:0] time_q;
  reg [15:0] time_d;
  reg en_q;
  reg en_d;
  reg [15:0] reloc_q;
  reg [15:0] reloc_d;
  reg [15:0] rdata_q;
  reg [15:0] rdata_d;
  reg [CNT_W-1:0] cnt_q;
  reg [CNT_W-1:0] cnt_d;
  reg [ROW_W-1:0] row_q;
  reg [ROW_W-1:0] row_d;
  reg [0:0] state_q;
  reg [0:0] state_d;
  reg [19:0] addr_q;
  reg [19:0] addr_d;

  // ------------------------------------------------------------
  // Nets
  // ------------------------------------------------------------
  wire [7:0] ofs;
  wire io_space;
  wire [11:0] block;
  wire [11:0] window;
  wire wr_hit;
  wire rd_hit;
  wire expire;
  wire served;
  wire [15:0] ctrl_view;

  // ------------------------------------------------------------
  // Register file decode
  // ------------------------------------------------------------
  assign ofs = {BUS_ADDR[7:1], 1'b0};
  assign io_space = reloc_q[`RELOC_IO_BIT];
  assign block = BUS_ADDR[19:8];
  // I/O space spans 64 Kbyte only, so its top four bits stay zero
  assign window = io_space ? {4'h0, reloc_q[7:0]} : reloc_q[11:0];
  // 128 word file placed on a 256 byte boundary in either space
  assign BUS_HIT = BUS_SEL && (BUS_IO == io_space) && (block == window);
  assign wr_hit = BUS_HIT && BUS_WR;
  assign rd_hit = BUS_HIT && BUS_RD;

  // ------------------------------------------------------------
  // Write path
  // ------------------------------------------------------------
  always @* begin
    base_d = base_q;
    time_d = time_q;
    en_d = en_q;
    reloc_d = reloc_q;
    if (wr_hit) begin
      case (ofs)
        `OFS_REFRESH_BASE: base_d = BUS_WDATA;
        `OFS_REFRESH_TIME: time_d = BUS_WDATA;
        `OFS_REFRESH_CTRL: en_d = BUS_WDATA[`CTRL_ENABLE_BIT];
        `OFS_RELOCATION: reloc_d = BUS_WDATA;
        default: base_d = base_q;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  // Control word: enable on top, live counter below, zeros between
  genvar i;
  generate
    for (i = 0; i < `CTRL_ENABLE_BIT; i = i + 1) begin : g_ctrl
      if (i < CNT_W) begin : g_cnt
        assign ctrl_view[i] = cnt_q[i];
      end else begin : g_pad
        assign ctrl_view[i] = 1'b0;
      end
    end
  endgenerate
  assign ctrl_view[`CTRL_ENABLE_BIT] = en_q;

  // Read data held until the next read; unmapped offsets read zero
  always @* begin
    rdata_d = rdata_q;
    if (rd_hit) begin
      case (ofs)
        `OFS_REFRESH_BASE: rdata_d = base_q;
        `OFS_REFRESH_TIME: rdata_d = time_q;
        `OFS_REFRESH_CTRL: rdata_d = ctrl_view;
        `OFS_RELOCATION: rdata_d = reloc_q;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Interval counter
  // ------------------------------------------------------------
  assign expire = en_q && (cnt_q == {CNT_W{1'b0}});
  assign served = (state_q == ST_PEND) && REFRESH_DONE;

  // Counter keeps running while a request waits, so a slow bus
  // does not stretch the average interval beyond one extra period.
  always @* begin
    if (!en_q) begin
      cnt_d = time_q[CNT_W-1:0];
    end else if (expire) begin
      cnt_d = time_q[CNT_W-1:0];
    end else begin
      cnt_d = cnt_q - CNT_ONE;
    end
  end

  // ------------------------------------------------------------
  // Request state
  // ------------------------------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (expire) begin
          state_d = ST_PEND;
        end
      end
      ST_PEND: begin
        // New expiry wins over completion, so no refresh is lost
        if (expire) begin
          state_d = ST_PEND;
        end else if (REFRESH_DONE || !en_q) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  assign REFRESH_REQ = (state_q == ST_PEND);

  // ------------------------------------------------------------
  // Row generator and refresh address
  // ------------------------------------------------------------
  always @* begin
    row_d = row_q;
    if (served) begin
      row_d = row_q + ROW_ONE;
    end
  end

  always @* begin
    addr_d = {base_q[7:1], row_q, 1'b0};
  end

  // ------------------------------------------------------------
  // Flip-flops
  // ------------------------------------------------------------
  always @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      base_q <= `RST_REFRESH_BASE;
      time_q <= `RST_REFRESH_TIME;
      en_q <= 1'b0;
      reloc_q <= `RST_RELOCATION;
      rdata_q <= 16'h0000;
    end else begin
      base_q <= base_d;
      time_q <= time_d;
      en_q <= en_d;
      reloc_q <= reloc_d;
      rdata_q <= rdata_d;
    end
  end

  always @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      cnt_q <= {CNT_W{1'b0}};
      row_q <= {ROW_W{1'b0}};
      state_q <= ST_IDLE;
      addr_q <= 20'h0_0000;
    end else begin
      cnt_q <= cnt_d;
      row_q <= row_d;
      state_q <= state_d;
      addr_q <= addr_d;
    end
  end

  always @* begin
    BUS_RDATA = rdata_q;
    REFRESH_ADDR = addr_q;
  end

endmodule
`default_nettype wire

// ### sim/refresh_sequencer_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "refresh_defs.vh"
module refresh_sequencer_sva (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic BUS_SEL,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  input wire logic [19:0] BUS_ADDR,
  input wire logic [15:0] BUS_WDATA,
  input wire logic [15:0] BUS_RDATA,
  input wire logic BUS_HIT,
  input wire logic REFRESH_REQ,
  input wire logic REFRESH_DONE,
  input wire logic [19:0] REFRESH_ADDR
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  sequence s_served;
    REFRESH_REQ && REFRESH_DONE;
  endsequence
  sequence s_waiting;
    REFRESH_REQ && !REFRESH_DONE && !(BUS_HIT && BUS_WR);
  endsequence
  sequence s_base_write;
    BUS_HIT && BUS_WR && ({BUS_ADDR[7:1], 1'b0} == `OFS_REFRESH_BASE);
  endsequence
  a_req_drops: assert property (s_served |=> !REFRESH_REQ)
    else $error("request held");
  a_row_steps: assert property (s_served |=> ##1
    REFRESH_ADDR[12:1] == $past(REFRESH_ADDR[12:1], 2) + 12'h001) else $error("row stuck");
  a_row_still: assert property ($changed(REFRESH_ADDR[12:1]) |-> $past(REFRESH_DONE, 2))
    else $error("row moved");
  a_low_bit: assert property (REFRESH_ADDR[0] == 1'b0) else $error("A0 set");
  a_req_held: assert property (s_waiting |=> REFRESH_REQ)
    else $error("request lost");
  a_base_lands: assert property (s_base_write |=> ##1
    REFRESH_ADDR[19:13] == $past(BUS_WDATA[7:1], 2)) else $error("base not applied");
  a_rdata_still: assert property (!(BUS_HIT && BUS_RD) |=> $stable(BUS_RDATA))
    else $error("read data moved");
endmodule
bind memory_refresh_sequencer refresh_sequencer_sva chk (.REF_CLK(REF_CLK), .NRST(NRST),
  .BUS_SEL(BUS_SEL), .BUS_WR(BUS_WR), .BUS_RD(BUS_RD), .BUS_ADDR(BUS_ADDR),
  .BUS_WDATA(BUS_WDATA), .BUS_RDATA(BUS_RDATA), .BUS_HIT(BUS_HIT),
  .REFRESH_REQ(REFRESH_REQ), .REFRESH_DONE(REFRESH_DONE), .REFRESH_ADDR(REFRESH_ADDR));
`default_nettype wire

// ### sim/bus_cycle_model.sv
`timescale 1ns/100ps
`default_nettype none
module bus_cycle_model #(parameter int WAIT = 2) (
  input wire logic REF_CLK,
  input wire logic REFRESH_REQ,
  output logic REFRESH_DONE = 1'b0
);
  int cnt = 0;
  // Read cycle takes WAIT clocks, then one done pulse
  wire busy = REFRESH_REQ && !REFRESH_DONE;
  always @(posedge REF_CLK) begin
    REFRESH_DONE <= busy && cnt == WAIT;
    cnt <= (busy && cnt < WAIT) ? cnt + 1 : 0;
  end
endmodule
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk = 0, rst_n = 0, sel = 0, io = 0, wr = 0, rd = 0, hit, req, done;
  logic [19:0] addr = 0, raddr;
  logic [15:0] wdata = 0, rdata;
  logic [11:0] blk = 12'h0FF;
  // Offset, word written, word read back
  logic [39:0] rows [4] = '{40'hB0_00A6_00A6, 40'hB2_0014_0014,
    40'hB6_1234_0000, 40'hB4_0000_0014};
  int bad_count = 0, samples_checked = 0, n = 0;
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
  $display("BAD %0t got %0h want %0h", $time, a, b); end end
  always #4 clk = ~clk;
  memory_refresh_sequencer dut (.REF_CLK(clk), .NRST(rst_n), .BUS_SEL(sel), .BUS_IO(io),
    .BUS_ADDR(addr), .BUS_WR(wr), .BUS_RD(rd), .BUS_WDATA(wdata), .BUS_RDATA(rdata),
    .BUS_HIT(hit), .REFRESH_REQ(req), .REFRESH_DONE(done), .REFRESH_ADDR(raddr));
  bus_cycle_model bce (.REF_CLK(clk), .REFRESH_REQ(req), .REFRESH_DONE(done));
  // Write then read back at the current window; reset window is memory space
  task automatic acc(input logic [7:0] o, input logic [15:0] d);
    @(negedge clk) {sel, wr, addr, wdata} = {2'h3, blk, o, d};
    @(negedge clk) {wr, rd} = 2'h1;
    @(negedge clk) {sel, rd} = 2'h0;
  endtask
  task automatic end_sim;
    $display("checks %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Tests need about 90 cycles; the limit of 2500 cycles is some 28 times that
  initial begin
    #20000;
    bad_count++;
    end_sim;
  end
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1;
    for (int i = 0; i < 4; i++) begin
      acc(rows[i][39:32], rows[i][31:16]);
      `CHK(rdata, rows[i][15:0])
    end
    acc(8'hB4, 16'h8000);
    while (req !== 1'b1 && n < 99) @(negedge clk) n++;
    `CHK(req, 1'b1)
    `CHK(raddr, 20'hA_6000)
    n = 0;
    while (req === 1'b1 && n < 99) @(negedge clk) n++;
    while (req !== 1'b1 && n < 99) @(negedge clk) n++;
    `CHK(n, 21)
    `CHK(raddr, 20'hA_6002)
    // Move the window into I/O space; the old place must miss
    acc(8'hA8, 16'h1012);
    blk = 12'h012;
    @(negedge clk) {sel, addr} = {1'b1, 20'h0_FFB0};
    #1 `CHK(hit, 1'b0)
    {io, addr} = {1'b1, 20'h0_12B0};
    #1 `CHK(hit, 1'b1)
    sel = 0;
    acc(8'hB0, 16'h00A6);
    `CHK(rdata, 16'h00A6)
    rst_n = 0;
    #1 `CHK({req, raddr}, 21'h00_0000)
    repeat (2) @(negedge clk);
    rst_n = 1;
    {io, blk} = {1'b0, 12'h0FF};
    repeat (2) @(negedge clk);
    `CHK({req, raddr}, 21'h00_0000)
    acc(8'hB4, 16'h0000);
    `CHK(rdata, 16'h0000)
    end_sim;
  end
endmodule
`default_nettype wire
